// ---- rtl/dlb_defines.vh ----
// constants for the diagnostic lamp blinker
// assumes a 10 MHz mclk_in; times are in milliseconds
`ifndef DLB_DEFINES_VH
`define DLB_DEFINES_VH
`define DLB_CLK_HZ 10000000
`define DLB_TICK_CYC 10000
`define DLB_BOOT_CYC 2'h2
`define DLB_LEAD_ON_MS 3000
`define DLB_DIGIT_GAP_MS 2000
`define DLB_PULSE_ON_MS 300
`define DLB_PULSE_OFF_MS 300
`define DLB_PULSE_GAP_MS 300
`define DLB_ST_RUN 3'h0
`define DLB_ST_LEAD 3'h1
`define DLB_ST_HI_ON 3'h2
`define DLB_ST_HI_OFF 3'h3
`define DLB_ST_HI_GAP 3'h4
`define DLB_ST_LO_ON 3'h5
`define DLB_ST_LO_OFF 3'h6
`define DLB_ST_LO_GAP 3'h7
`endif

// ---- rtl/dlb_sync.v ----
// two-flop synchroniser for a bus of level inputs
// assumes inputs are asynchronous to clk_in
`default_nettype none
module dlb_sync #(
  parameter W = 1
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire [W-1:0] d_in,
  output reg [W-1:0] q_out
);
  reg [W-1:0] meta_r;
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_r <= {W{1'b0}};
      q_out <= {W{1'b0}};
    end
    else
    begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/dlb_blinker.v ----
// ready and fault lamp sequencer for the off-line diagnostics
// assumes the test engine reports pass/error as async levels or pulses
//
// Overview of operation
// - the test selected by the jumpers is started straight after reset with no trigger.
// - every error-free pass inverts the ready lamp.
// - passes repeat without limit while no error is seen.
// - an error stops testing, turns the ready lamp off and starts the fault blink loop.
// - each blink loop begins with the fault lamp on for three seconds.
// - then the upper hex digit is shown as short pulses, followed by two seconds off.
// - then the lower digit as short pulses, two seconds off, and the loop restarts.
// - the loop only ends on power removal or a new diagnostic start.
// - the blinked code is the same code reported in the extended status byte.
`default_nettype none
`include "dlb_defines.vh"
module dlb_blinker #(
  parameter PULSE_ON_MS = `DLB_PULSE_ON_MS,
  parameter PULSE_OFF_MS = `DLB_PULSE_OFF_MS,
  parameter PULSE_GAP_MS = `DLB_PULSE_GAP_MS,
  parameter TICK_CYC = `DLB_TICK_CYC
) (
  input wire mclk_in,
  input wire rst_n_in,
  input wire [4:0] test_select_jumpers_in,
  input wire restart_in,
  input wire pass_done_in,
  input wire error_in,
  input wire [7:0] error_code_in,
  output reg [4:0] test_select_out,
  output reg test_run_out,
  output reg ready_lamp_out,
  output reg fault_lamp_out,
  output reg [7:0] status_code_out
);
  wire [4:0] jmp_s;
  wire [2:0] ev_s;
  dlb_sync #(.W(8)) u_sync (
    .clk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .d_in({test_select_jumpers_in, restart_in, pass_done_in, error_in}),
    .q_out({jmp_s, ev_s})
  );
  reg [2:0] ev_d_r;
  wire restart_p = ev_s[2] & ~ev_d_r[2];
  wire pass_p = ev_s[1] & ~ev_d_r[1];
  wire err_p = ev_s[0] & ~ev_d_r[0];
  // code is held by the test engine while error is high, sampled at the error edge
  wire [7:0] code_s;
  dlb_sync #(.W(8)) u_sync_code (
    .clk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .d_in(error_code_in),
    .q_out(code_s)
  );
  // state codes of the lamp sequencer
  localparam [2:0] ST_RUN = `DLB_ST_RUN;
  localparam [2:0] ST_LEAD = `DLB_ST_LEAD;
  localparam [2:0] ST_HI_ON = `DLB_ST_HI_ON;
  localparam [2:0] ST_HI_OFF = `DLB_ST_HI_OFF;
  localparam [2:0] ST_HI_GAP = `DLB_ST_HI_GAP;
  localparam [2:0] ST_LO_ON = `DLB_ST_LO_ON;
  localparam [2:0] ST_LO_OFF = `DLB_ST_LO_OFF;
  localparam [2:0] ST_LO_GAP = `DLB_ST_LO_GAP;
  // countdown loads: one less than the length, as the zero count is the last tick
  localparam [13:0] TICK_LAST = TICK_CYC - 1;
  localparam [11:0] LEAD_LD = `DLB_LEAD_ON_MS - 1;
  localparam [11:0] DIGIT_GAP_LD = `DLB_DIGIT_GAP_MS - 1;
  localparam [11:0] PULSE_ON_LD = PULSE_ON_MS - 1;
  localparam [11:0] PULSE_OFF_LD = PULSE_OFF_MS - 1;
  localparam [11:0] PULSE_GAP_LD = PULSE_GAP_MS - 1;
  // one-ms enable pulse
  reg [13:0] tick_cnt_r;
  reg tick_r;
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tick_cnt_r <= 14'h0000;
      tick_r <= 1'b0;
    end
    else if (tick_cnt_r == TICK_LAST)
    begin
      tick_cnt_r <= 14'h0000;
      tick_r <= 1'b1;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 14'h0001;
      tick_r <= 1'b0;
    end
  end
  // hold the launch until the jumper synchroniser shows pin values, not its reset value
  reg [1:0] boot_r;
  reg started_r;
  wire launch_w = (!started_r && (boot_r == `DLB_BOOT_CYC)) || restart_p;
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      boot_r <= 2'h0;
    else if (boot_r != `DLB_BOOT_CYC)
      boot_r <= boot_r + 2'h1;
  end
  reg [2:0] st_r;
  reg [11:0] ms_r;
  reg [3:0] left_r;
  // an interval runs out on the tick that finds its countdown at zero
  wire ms_done = tick_r && (ms_r == 12'h000);
  // digit shown next: upper after the lead, lower after the upper digit's gap
  wire [3:0] digit_w = (st_r == ST_LEAD) ? status_code_out[7:4] : status_code_out[3:0];
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      // lamps dark and test idle until the launch
      ev_d_r <= 3'h0;
      st_r <= ST_RUN;
      ms_r <= 12'h000;
      left_r <= 4'h0;
      started_r <= 1'b0;
      test_select_out <= 5'h00;
      test_run_out <= 1'b0;
      ready_lamp_out <= 1'b0;
      fault_lamp_out <= 1'b0;
      status_code_out <= 8'h00;
    end
    else
    begin
      ev_d_r <= ev_s;
      if (launch_w)
      begin
        // latch jumpers and launch the chosen test
        started_r <= 1'b1;
        test_select_out <= jmp_s;
        test_run_out <= 1'b1;
        st_r <= ST_RUN;
        fault_lamp_out <= 1'b0;
        ready_lamp_out <= 1'b0;
      end
      else if (st_r == ST_RUN)
      begin
        // an error halts the test and starts the blink loop
        if (err_p)
        begin
          test_run_out <= 1'b0;
          ready_lamp_out <= 1'b0;
          fault_lamp_out <= 1'b1;
          status_code_out <= code_s;
          ms_r <= LEAD_LD;
          st_r <= ST_LEAD;
        end
        else if (pass_p)
          ready_lamp_out <= ~ready_lamp_out;
      end
      else if (ms_done)
      begin
        // interval over: step to the next part of the blink loop
        case (st_r)
          ST_LEAD, ST_HI_GAP:
          begin
            // a zero digit skips its pulses and goes to the long gap
            left_r <= digit_w;
            fault_lamp_out <= 1'b0;
            if (digit_w == 4'h0)
            begin
              ms_r <= DIGIT_GAP_LD;
              st_r <= (st_r == ST_LEAD) ? ST_HI_GAP : ST_LO_GAP;
            end
            else
            begin
              ms_r <= PULSE_GAP_LD;
              st_r <= (st_r == ST_LEAD) ? ST_HI_OFF : ST_LO_OFF;
            end
          end
          ST_HI_OFF, ST_LO_OFF:
          begin
            if (left_r == 4'h0)
            begin
              ms_r <= DIGIT_GAP_LD;
              st_r <= (st_r == ST_HI_OFF) ? ST_HI_GAP : ST_LO_GAP;
            end
            else
            begin
              // light the next pulse of this digit
              fault_lamp_out <= 1'b1;
              left_r <= left_r - 4'h1;
              ms_r <= PULSE_ON_LD;
              st_r <= (st_r == ST_HI_OFF) ? ST_HI_ON : ST_LO_ON;
            end
          end
          ST_HI_ON, ST_LO_ON:
          begin
            fault_lamp_out <= 1'b0;
            // last pulse goes straight to the long gap
            if (left_r == 4'h0)
            begin
              ms_r <= DIGIT_GAP_LD;
              st_r <= (st_r == ST_HI_ON) ? ST_HI_GAP : ST_LO_GAP;
            end
            else
            begin
              ms_r <= PULSE_OFF_LD;
              st_r <= (st_r == ST_HI_ON) ? ST_HI_OFF : ST_LO_OFF;
            end
          end
          ST_LO_GAP:
          begin
            // code shown: back to the lead-in
            fault_lamp_out <= 1'b1;
            ms_r <= LEAD_LD;
            st_r <= ST_LEAD;
          end
          default:
            st_r <= ST_RUN;
        endcase
      end
      else if (tick_r)
        ms_r <= ms_r - 12'h001;
    end
  end
endmodule
`default_nettype wire

// ---- dv/dlb_blinker_asserts.sv ----
// port checker for the lamp sequencer
// assumes bind into dlb_blinker, timing parameters handed on
`default_nettype none
module dlb_blinker_asserts #(
  parameter PULSE_ON_MS = 300,
  parameter PULSE_GAP_MS = 300,
  parameter TICK_CYC = 10000
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic pass_done_in,
  input wire logic error_in,
  input wire logic restart_in,
  input wire logic [7:0] error_code_in,
  input wire logic test_run_out,
  input wire logic ready_lamp_out,
  input wire logic fault_lamp_out,
  input wire logic [7:0] status_code_out
);
  localparam int M = 2 * TICK_CYC + 2;
  localparam int LEAD = 3000 * TICK_CYC;
  localparam int PON = PULSE_ON_MS * TICK_CYC;
  int on_len_r;
  int off_len_r;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  always @(posedge mclk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      on_len_r <= 0;
      off_len_r <= 0;
    end
    else
    begin
      on_len_r <= fault_lamp_out ? on_len_r + 1 : 0;
      off_len_r <= fault_lamp_out ? 0 : off_len_r + 1;
    end
  a_pass_toggles: assert property ($rose(pass_done_in) && test_run_out |-> ##[2:6] $changed(ready_lamp_out))
    else $error("ready lamp missed a pass");
  a_error_halts: assert property ($rose(error_in) && test_run_out |-> ##[2:6] (fault_lamp_out && !ready_lamp_out && !test_run_out))
    else $error("error did not halt");
  a_dark_halted: assert property (!test_run_out |-> !ready_lamp_out)
    else $error("ready lamp lit while halted");
  a_code_match: assert property ($fell(test_run_out) |-> status_code_out == error_code_in)
    else $error("status code differs");
  a_code_held: assert property (!test_run_out ##1 !test_run_out |-> $stable(status_code_out))
    else $error("status code moved");
  a_restart_exits: assert property ($rose(restart_in) |-> ##[2:6] (test_run_out && !fault_lamp_out))
    else $error("restart ignored");
  a_on_length: assert property ($fell(fault_lamp_out) && !test_run_out |->
    on_len_r inside {[LEAD-M:LEAD+M], [PON-M:PON+M]})
    else $error("bad on time");
  a_off_bounded: assert property ($rose(fault_lamp_out) && !$past(test_run_out) |->
    off_len_r <= (4000 + PULSE_GAP_MS) * TICK_CYC + M)
    else $error("off time too long");
endmodule
bind dlb_blinker dlb_blinker_asserts #(.PULSE_ON_MS(PULSE_ON_MS), .PULSE_GAP_MS(PULSE_GAP_MS),
  .TICK_CYC(TICK_CYC)) u_chk (.*);
`default_nettype wire

// ---- dv/tb_top.sv ----
// self-checking bench for the lamp sequencer
// assumes dlb_blinker with the tick cut to one clock
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in = 0, rst_n_in = 0, restart_in = 0, pass_done_in = 0, error_in = 0, run, rdy, flt, exp_rdy;
  logic [4:0] jmp = 0, sel;
  logic [7:0] code = 0, stat, r;
  int n_mismatch = 0, n_checks = 0, n, c;
  int exp_q[$];
  dlb_blinker #(.PULSE_ON_MS(20), .PULSE_OFF_MS(20), .PULSE_GAP_MS(20), .TICK_CYC(1)) DUT (.mclk_in(mclk_in),
    .rst_n_in(rst_n_in), .test_select_jumpers_in(jmp), .restart_in(restart_in), .pass_done_in(pass_done_in),
    .error_in(error_in), .error_code_in(code), .test_select_out(sel), .test_run_out(run), .ready_lamp_out(rdy),
    .fault_lamp_out(flt), .status_code_out(stat));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (e !== s)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic len(input logic lv);
    n = 0;
    while (flt === lv && n < 9000)
    begin
      @(negedge mclk_in);
      n++;
    end
  endtask
  task automatic blink(input logic [7:0] k);
    code = k;
    repeat (5) @(negedge mclk_in);
    error_in = 1;
    len(0);
    error_in = 0;
    len(1);
    chk("lead", 8'h01, {7'h00, n inside {[2998:3002]}});
    chk("halt", 8'h00, {6'h00, run, rdy});
    chk("status", k, stat);
    exp_q.push_back(k[7:4]);
    exp_q.push_back(k[3:0]);
    pass_done_in = 1;
    repeat (4) @(negedge mclk_in);
    pass_done_in = 0;
    repeat (4) @(negedge mclk_in);
    chk("ignored", 8'h00, {6'h00, run, rdy});
    for (int i = 1; i >= 0; i--)
    begin
      c = 0;
      len(0);
      while (n < 1000)
      begin
        len(1);
        c++;
        len(0);
      end
      chk("digit", exp_q.pop_front(), c[7:0]);
      chk("gap", 8'h01, {7'h00, n inside {[1999:2022]}});
    end
    len(1);
    chk("again", 8'h01, {7'h00, n inside {[2998:3002]}});
    // restart as the first pulse of the code lights, with new jumpers
    len(0);
    jmp = $urandom;
    restart_in = 1;
    repeat (8) @(negedge mclk_in);
    restart_in = 0;
    chk("exit", 8'h04, {5'h00, run, flt, rdy});
    chk("reselect", {3'h0, jmp}, sel);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
    forever #50 mclk_in = ~mclk_in;
  initial
  begin
    repeat (80000) @(posedge mclk_in);
    n_mismatch++;
    $display("BAD watchdog exp done got hang");
    finish_test();
  end
  initial
  begin
    void'($urandom(32'h7444));
    jmp = $urandom;
    r = $urandom | 1;
    repeat (20) @(negedge mclk_in);
    rst_n_in = 1;
    repeat (6) @(negedge mclk_in);
    chk("select", {3'h0, jmp}, sel);
    chk("run", 8'h01, {7'h00, run});
    exp_rdy = 0;
    repeat (5)
    begin
      pass_done_in = 1;
      repeat (5) @(negedge mclk_in);
      pass_done_in = 0;
      repeat (5) @(negedge mclk_in);
      exp_rdy = ~exp_rdy;
      chk("ready", {7'h00, exp_rdy}, {7'h00, rdy});
    end
    blink(8'h34);
    blink(8'h05);
    blink(r);
    finish_test();
  end
endmodule
`default_nettype wire
